//--- common/flash_host_pkg.sv
/*
 * Constants shared by the flash command host: command codes, unlock addresses,
 * bus strobe timing, status bit positions, load window and resume gap.
 * Assumes a 10 MHz system clock and a parallel NOR flash in word mode.
 */
`default_nettype none
package flash_host_pkg;
	localparam int CLK_MHZ = 10;
	// unlock cycle addresses and data
	localparam logic [19:0] UNLOCK_ADDR_1 = 20'h00555;
	localparam logic [19:0] UNLOCK_ADDR_2 = 20'h002AA;
	localparam logic [7:0] UNLOCK_DATA_1 = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
	// command codes
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	// positions of the polling bit and the time limit bit in the data word
	localparam int POLL_BIT = 7;
	localparam int TIME_LIMIT_BIT = 5;
	// strobe phase lengths, ns
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	// sector load window, us; host does not time loads, each OP_LOAD is written when ordered
	localparam int LOAD_WINDOW_US = 50;
	localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ;
	// least time from resume to next suspend, us
	localparam int RESUME_GAP_US = 400;
	localparam int RESUME_GAP_CYC = RESUME_GAP_US * CLK_MHZ;
	// user operation codes
	typedef enum logic [2:0] {
		OP_RESET = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_ERASE = 3'h2,
		OP_LOAD = 3'h3,
		OP_SUSPEND = 3'h4,
		OP_RESUME = 3'h5,
		OP_READ = 3'h6
	} op_type;
endpackage
`default_nettype wire

//--- logic/flash_bus_cycle.sv
/*
 * One flash bus cycle: write or read with chip select, write strobe and
 * output strobe.
 * Assumes the flash data bus is a two-way pin resolved by the bench.
 */
`default_nettype none
module flash_bus_cycle #(
	parameter int PHASE = flash_host_pkg::STROBE_CYC
) (
	input wire logic clk_i,
	input wire logic reset_i,
	// request
	input wire logic start_i,
	input wire logic write_i,
	input wire logic [19:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic done_o,
	output logic [15:0] rdata_o,
	// flash pins
	output logic [19:0] flash_addr_o,
	output logic chip_select_n_o,
	output logic write_strobe_n_o,
	output logic output_strobe_n_o,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [15:0] flash_dq_i
);
	typedef enum logic [1:0] {C_IDLE = 2'h0, C_SETUP = 2'h1, C_STROBE = 2'h3, C_HOLD = 2'h2}
		cyc_type;
	cyc_type state, next_state;
	logic [7:0] cnt, next_cnt;
	logic wr, next_wr;
	logic [15:0] dq_s1, dq_s2;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
		end else begin
			dq_s1 <= flash_dq_i;
			dq_s2 <= dq_s1;
		end
	end

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_wr = wr;
		unique case (state)
			C_IDLE: if (start_i) begin
				next_state = C_SETUP;
				next_wr = write_i;
				next_cnt = 8'(PHASE);
			end
			C_SETUP: begin
				next_state = C_STROBE;
				next_cnt = 8'(PHASE + (wr ? 0 : 2));
			end
			C_STROBE: if (cnt == 8'h00) next_state = C_HOLD;
				else next_cnt = cnt - 8'h01;
			C_HOLD: next_state = C_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= C_IDLE;
			cnt <= 8'h00;
			wr <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h0000;
			flash_addr_o <= 20'h00000;
			chip_select_n_o <= 1'b1;
			write_strobe_n_o <= 1'b1;
			output_strobe_n_o <= 1'b1;
			flash_dq_o <= 16'h0000;
			flash_dq_oe_o <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			wr <= next_wr;
			done_o <= (state == C_HOLD);
			if (state == C_IDLE && start_i) begin
				flash_addr_o <= addr_i;
				flash_dq_o <= wdata_i;
			end
			chip_select_n_o <= !(next_state != C_IDLE);
			// address latched on falling strobe, data on rising edge
			write_strobe_n_o <= !(next_state == C_STROBE && next_wr);
			output_strobe_n_o <= !(next_state == C_STROBE && !next_wr);
			flash_dq_oe_o <= (next_state != C_IDLE) && next_wr;
			if (state == C_STROBE && cnt == 8'h00 && !wr)
				rdata_o <= dq_s2;
		end
	end
endmodule
`default_nettype wire

//--- logic/flash_command_host.sv
/*
 * Host side command sequencer for a parallel NOR flash: reset, program,
 * sector erase with sector loading, suspend, resume, read and status polling.
 * Assumes the flash holds no clock; all timing is made here from clk_i.
 */
// Overview of operation
// - sector erase is six writes: unlocks, 80H, unlocks, 30H
// - each further sector load within 50us of previous write; host does not time loads, each OP_LOAD is written when ordered
// - host waits 400us after resume before next suspend
// - program is four writes: unlocks, setup, address and data
// - after polling bit flips true, read once more for full data
// - reset command is F0H
`default_nettype none
module flash_command_host #(
	parameter int RESUME_GAP = flash_host_pkg::RESUME_GAP_CYC,
	parameter int POLL_LIMIT = 1_000_000
) (
	input wire logic clk_i,
	input wire logic reset_i,
	// user orders
	input wire logic req_i,
	input wire flash_host_pkg::op_type op_i,
	input wire logic [19:0] addr_i,
	input wire logic [15:0] data_i,
	output logic ready_o,
	output logic done_o,
	output logic fail_o,
	output logic suspended_o,
	output logic [15:0] rdata_o,
	// flash pins
	output logic [19:0] flash_addr_o,
	output logic chip_select_n_o,
	output logic write_strobe_n_o,
	output logic output_strobe_n_o,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe_o,
	input wire logic [15:0] flash_dq_i
);
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_WRITE = 3'h1,
		S_WAIT = 3'h3,
		S_POLL = 3'h2,
		S_CHECK = 3'h6,
		S_FINAL = 3'h7,
		S_DONE = 3'h5
	} st_type;

	st_type state, next_state;
	logic [2:0] step, next_step;
	logic [2:0] nsteps, next_nsteps;
	flash_host_pkg::op_type op, next_op;
	logic [19:0] addr, next_addr;
	logic [15:0] data, next_data;
	logic poll, next_poll;
	logic fail, next_fail;
	logic susp, next_susp;
	logic [15:0] rdata, next_rdata;
	logic [31:0] timer, next_timer;
	logic [31:0] gap, next_gap;
	logic bus_start, bus_write, bus_done;
	logic [19:0] bus_addr;
	logic [15:0] bus_wdata, bus_rdata;

	// address and data of write cycle n of the current sequence
	function automatic logic [35:0] seq_word(input flash_host_pkg::op_type o,
		input logic [2:0] n, input logic [19:0] a, input logic [15:0] d);
		logic [35:0] w;
		w = {a, d};
		unique case (o)
			flash_host_pkg::OP_RESET: w = {a, 8'h00, flash_host_pkg::CMD_RESET};
			flash_host_pkg::OP_SUSPEND: w = {a, 8'h00, flash_host_pkg::CMD_SUSPEND};
			flash_host_pkg::OP_RESUME: w = {a, 8'h00, flash_host_pkg::CMD_RESUME};
			flash_host_pkg::OP_LOAD: w = {a, 8'h00, flash_host_pkg::CMD_SECTOR_ERASE};
			flash_host_pkg::OP_PROGRAM:
				unique case (n)
					3'h0: w = {flash_host_pkg::UNLOCK_ADDR_1, 8'h00, flash_host_pkg::UNLOCK_DATA_1};
					3'h1: w = {flash_host_pkg::UNLOCK_ADDR_2, 8'h00, flash_host_pkg::UNLOCK_DATA_2};
					3'h2: w = {flash_host_pkg::UNLOCK_ADDR_1, 8'h00, flash_host_pkg::CMD_PROGRAM};
					default: w = {a, d};
				endcase
			flash_host_pkg::OP_ERASE:
				unique case (n)
					3'h0, 3'h3: w = {flash_host_pkg::UNLOCK_ADDR_1, 8'h00, flash_host_pkg::UNLOCK_DATA_1};
					3'h1, 3'h4: w = {flash_host_pkg::UNLOCK_ADDR_2, 8'h00, flash_host_pkg::UNLOCK_DATA_2};
					3'h2: w = {flash_host_pkg::UNLOCK_ADDR_1, 8'h00, flash_host_pkg::CMD_ERASE_SETUP};
					default: w = {a, 8'h00, flash_host_pkg::CMD_SECTOR_ERASE};
				endcase
			default: w = {a, d};
		endcase
		return w;
	endfunction

	always_comb begin
		next_state = state;
		next_step = step;
		next_nsteps = nsteps;
		next_op = op;
		next_addr = addr;
		next_data = data;
		next_poll = poll;
		next_fail = fail;
		next_susp = susp;
		next_rdata = rdata;
		next_timer = timer;
		next_gap = (gap != 32'h0) ? gap - 32'h1 : gap;
		bus_start = 1'b0;
		bus_write = 1'b1;
		{bus_addr, bus_wdata} = seq_word(op, step, addr, data);
		unique case (state)
			S_IDLE: if (req_i) begin
				next_op = op_i;
				next_addr = addr_i;
				next_data = data_i;
				next_step = 3'h0;
				next_fail = 1'b0;
				next_timer = 32'h0;
				unique case (op_i)
					flash_host_pkg::OP_PROGRAM: next_nsteps = 3'h4;
					flash_host_pkg::OP_ERASE: next_nsteps = 3'h6;
					flash_host_pkg::OP_READ: next_nsteps = 3'h0;
					default: next_nsteps = 3'h1;
				endcase
				// suspend waits out the gap after a resume
				if (op_i == flash_host_pkg::OP_SUSPEND && gap != 32'h0) begin
					next_state = S_WAIT;
				end else begin
					next_state = (op_i == flash_host_pkg::OP_READ) ? S_FINAL : S_WRITE;
				end
			end
			S_WAIT: if (gap == 32'h0) next_state = S_WRITE;
			S_WRITE: begin
				bus_start = 1'b1;
				if (bus_done) begin
					bus_start = 1'b0;
					next_step = step + 3'h1;
					if (step + 3'h1 == nsteps) begin
						unique case (op)
							// writes back to back stay far inside the load window
							flash_host_pkg::OP_ERASE, flash_host_pkg::OP_LOAD: begin
								next_state = S_DONE;
								next_susp = 1'b0;
							end
							flash_host_pkg::OP_PROGRAM: next_state = S_POLL;
							flash_host_pkg::OP_SUSPEND: begin
								next_susp = 1'b1;
								next_state = S_POLL;
							end
							flash_host_pkg::OP_RESUME: begin
								if (susp) next_gap = 32'(RESUME_GAP);
								next_susp = 1'b0;
								next_state = S_DONE;
							end
							default: begin
								next_susp = 1'b0;
								next_state = S_DONE;
							end
						endcase
					end
				end
			end
			S_POLL: begin
				bus_start = 1'b1;
				bus_write = 1'b0;
				bus_addr = addr;
				if (bus_done) begin
					bus_start = 1'b0;
					next_rdata = bus_rdata;
					next_timer = timer + 32'h1;
					next_state = S_CHECK;
				end
			end
			S_CHECK: begin
				// program: true bit means done; suspend: one means done
				if (op == flash_host_pkg::OP_PROGRAM)
					next_poll = (rdata[flash_host_pkg::POLL_BIT] ==
						data[flash_host_pkg::POLL_BIT]);
				else
					next_poll = rdata[flash_host_pkg::POLL_BIT];
				if ((op == flash_host_pkg::OP_PROGRAM && rdata[flash_host_pkg::POLL_BIT] ==
					data[flash_host_pkg::POLL_BIT]) || (op != flash_host_pkg::OP_PROGRAM &&
					rdata[flash_host_pkg::POLL_BIT])) begin
					next_state = S_FINAL;
				end else if (rdata[flash_host_pkg::TIME_LIMIT_BIT] || timer == 32'(POLL_LIMIT)) begin
					next_fail = 1'b1;
					next_op = flash_host_pkg::OP_RESET;
					next_step = 3'h0;
					next_nsteps = 3'h1;
					next_state = S_WRITE;
				end else begin
					next_state = S_POLL;
				end
			end
			S_FINAL: begin
				bus_start = 1'b1;
				bus_write = 1'b0;
				bus_addr = addr;
				if (bus_done) begin
					bus_start = 1'b0;
					next_rdata = bus_rdata;
					next_state = S_DONE;
				end
			end
			S_DONE: next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= S_IDLE;
			step <= 3'h0;
			nsteps <= 3'h0;
			op <= flash_host_pkg::OP_RESET;
			addr <= 20'h00000;
			data <= 16'h0000;
			poll <= 1'b0;
			fail <= 1'b0;
			susp <= 1'b0;
			rdata <= 16'h0000;
			timer <= 32'h0;
			gap <= 32'h0;
			ready_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			suspended_o <= 1'b0;
			rdata_o <= 16'h0000;
		end else begin
			state <= next_state;
			step <= next_step;
			nsteps <= next_nsteps;
			op <= next_op;
			addr <= next_addr;
			data <= next_data;
			poll <= next_poll;
			fail <= next_fail;
			susp <= next_susp;
			rdata <= next_rdata;
			timer <= next_timer;
			gap <= next_gap;
			ready_o <= (next_state == S_IDLE);
			done_o <= (state == S_DONE);
			fail_o <= next_fail;
			suspended_o <= next_susp;
			rdata_o <= next_rdata;
		end
	end

	// erase runs self-timed in the flash; host only writes and returns
	flash_bus_cycle u_cycle (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.start_i(bus_start),
		.write_i(bus_write),
		.addr_i(bus_addr),
		.wdata_i(bus_wdata),
		.done_o(bus_done),
		.rdata_o(bus_rdata),
		.flash_addr_o(flash_addr_o),
		.chip_select_n_o(chip_select_n_o),
		.write_strobe_n_o(write_strobe_n_o),
		.output_strobe_n_o(output_strobe_n_o),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe_o(flash_dq_oe_o),
		.flash_dq_i(flash_dq_i)
	);
endmodule
`default_nettype wire

//--- bench/flash_host_chk.sv
/*
 * Checker for the flash command host: strobe framing, write hold,
 * order handshake and the spacing between resume and suspend.
 * Assumes it is bound to flash_command_host and sees only its ports.
 */
`default_nettype none
module flash_host_chk #(
	parameter int RESUME_GAP = 4000,
	parameter int POLL_LIMIT = 1000000
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic req_i,
	input wire flash_host_pkg::op_type op_i,
	input wire logic ready_o,
	input wire logic done_o,
	input wire logic suspended_o,
	input wire logic [19:0] flash_addr_o,
	input wire logic chip_select_n_o,
	input wire logic write_strobe_n_o,
	input wire logic output_strobe_n_o,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_o
);
	int gap;
	int next_gap;
	// cycles since the last resume order was taken, saturating
	always_comb begin
		next_gap = gap;
		if (req_i && ready_o && op_i == flash_host_pkg::OP_RESUME)
			next_gap = 0;
		else if (gap < RESUME_GAP)
			next_gap = gap + 1;
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			gap <= RESUME_GAP;
		else
			gap <= next_gap;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	a_strobe_needs_cs: assert property (
		(!write_strobe_n_o || !output_strobe_n_o) |-> !chip_select_n_o)
		else $error("strobe without chip select");
	a_strobes_apart: assert property (write_strobe_n_o || output_strobe_n_o)
		else $error("both strobes low");
	a_write_drives: assert property (!write_strobe_n_o |-> flash_dq_oe_o)
		else $error("write strobe without data drive");
	a_read_released: assert property (!output_strobe_n_o |-> !flash_dq_oe_o)
		else $error("data driven during read");
	a_write_hold: assert property (
		!write_strobe_n_o && $past(!write_strobe_n_o)
		|-> $stable(flash_addr_o) && $stable(flash_dq_o))
		else $error("address or data moved under write strobe");
	a_we_width: assert property (
		$fell(write_strobe_n_o) |-> !write_strobe_n_o[*2] ##1 write_strobe_n_o)
		else $error("write strobe width");
	a_cs_after_we: assert property ($rose(write_strobe_n_o) |=> chip_select_n_o)
		else $error("chip select held after write");
	a_gap_suspend: assert property (
		$fell(write_strobe_n_o) && flash_dq_o[7:0] == flash_host_pkg::CMD_SUSPEND
		|-> gap == RESUME_GAP)
		else $error("suspend too soon after resume");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	a_busy_taken: assert property (req_i && ready_o |=> !ready_o)
		else $error("ready after order taken");
	a_idle_quiet: assert property (
		ready_o |-> chip_select_n_o && write_strobe_n_o && output_strobe_n_o)
		else $error("bus active while idle");
	cover property (done_o && suspended_o);
	cover property ($rose(suspended_o));
	cover property ($fell(write_strobe_n_o) && flash_dq_o[7:0] == 8'hA0);
endmodule
bind flash_command_host flash_host_chk #(.RESUME_GAP(RESUME_GAP), .POLL_LIMIT(POLL_LIMIT))
	flash_host_chk_inst (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .op_i(op_i),
	.ready_o(ready_o), .done_o(done_o), .suspended_o(suspended_o), .flash_addr_o(flash_addr_o),
	.chip_select_n_o(chip_select_n_o), .write_strobe_n_o(write_strobe_n_o),
	.output_strobe_n_o(output_strobe_n_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o));
`default_nettype wire

//--- bench/flash_model.sv
/*
 * Behavioural flash device: command decoder, array, program, sector erase
 * with load window, suspend and resume, polling status.
 * Assumes word mode and a host that frames each strobe inside chip select.
 */
`default_nettype none
module flash_model #(
	parameter int PROG_NS = 5000,
	parameter int ERASE_NS = 300000,
	parameter int WINDOW_NS = 50000
) (
	input wire logic [19:0] addr_i,
	input wire logic chip_select_n_i,
	input wire logic write_strobe_n_i,
	input wire logic output_strobe_n_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [logic [19:0]];
	logic [255:0] sec = '0;
	logic [19:0] la;
	logic [19:0] pa;
	logic [15:0] pd;
	logic pbusy = 1'b0;
	logic stale = 1'b0;
	int stp = 0;
	// erase phase: 0 none, 1 loading, 2 erasing, 3 suspended
	int ph = 0;
	time t_end = 0;
	time left = 0;
	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		if (pbusy)
			return;
		if (stp == 6) begin
			pa = a;
			pd = d;
			pbusy = 1'b1;
			t_end = $time + PROG_NS;
			stp = 0;
		end else if (d[7:0] == 8'hF0) begin
			stp = 0;
			if (ph == 1)
				ph = 0;
		end else if (ph == 1 && d[7:0] == 8'h30) begin
			sec[a[19:12]] = 1'b1;
			t_end = $time + WINDOW_NS;
		end else if (d[7:0] == 8'hB0) begin
			if (ph == 1 || ph == 2) begin
				left = ph == 1 ? ERASE_NS : t_end - $time;
				ph = 3;
			end
		end else if (ph == 3 && d[7:0] == 8'h30) begin
			ph = 2;
			t_end = $time + left;
		end else if (ph == 1) begin
			ph = 0;
			stp = 0;
		end else if (ph != 2) begin
			case (stp)
				0: stp = (a == 20'h00555 && d[7:0] == 8'hAA) ? 1 : 0;
				1: stp = (a == 20'h002AA && d[7:0] == 8'h55) ? 2 : 0;
				2: stp = d[7:0] == 8'hA0 ? 6 : ((d[7:0] == 8'h80 && ph == 0) ? 3 : 0);
				3: stp = (a == 20'h00555 && d[7:0] == 8'hAA) ? 4 : 0;
				4: stp = (a == 20'h002AA && d[7:0] == 8'h55) ? 5 : 0;
				default: begin
					stp = 0;
					if (d[7:0] == 8'h30) begin
						sec = '0;
						sec[a[19:12]] = 1'b1;
						ph = 1;
						t_end = $time + WINDOW_NS;
					end
				end
			endcase
		end
	endtask
	function automatic logic [15:0] rd(input logic [19:0] a);
		if (pbusy && a == pa)
			return {8'h00, ~pd[7], 7'h00};
		if (ph != 0 && sec[a[19:12]])
			return ph == 3 ? 16'h0080 : 16'h0000;
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	always @(negedge write_strobe_n_i)
		la = addr_i;
	always @(posedge write_strobe_n_i)
		if (!chip_select_n_i)
			wr(la, dq_i);
	always @(negedge output_strobe_n_i)
		if (!chip_select_n_i) begin
			dq_o = rd(addr_i);
			// first read after a program ends: only the polling bit is settled
			if (stale && addr_i == pa)
				dq_o = {8'h00, dq_o[7], 7'h00};
			stale = 1'b0;
		end
	// a released bus shows the inverse of its last value
	always @(posedge output_strobe_n_i)
		dq_o = ~dq_o;
	initial dq_o = 16'h5A5A;
	always #100 begin
		if (pbusy && $time >= t_end) begin
			mem[pa] = (mem.exists(pa) ? mem[pa] : 16'hFFFF) & pd;
			pbusy = 1'b0;
			stale = 1'b1;
		end
		if (ph == 1 && $time >= t_end) begin
			ph = 2;
			t_end = $time + ERASE_NS;
		end else if (ph == 2 && $time >= t_end) begin
			foreach (mem[k])
				if (sec[k[19:12]])
					mem[k] = 16'hFFFF;
			ph = 0;
		end
	end
endmodule
`default_nettype wire

//--- bench/tb_top.sv
/*
 * Self-checking bench for flash_command_host against a behavioural flash.
 * Assumes the package, design and checker files are compiled first.
 */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic req_i = 1'b0;
	flash_host_pkg::op_type op_i = flash_host_pkg::OP_READ;
	logic [19:0] addr_i = '0;
	logic [15:0] data_i = '0;
	logic ready_o, done_o, fail_o, suspended_o;
	logic [15:0] rdata_o, flash_dq_o, dev_dq, dq, wr_data;
	logic [19:0] flash_addr_o;
	logic chip_select_n_o, write_strobe_n_o, output_strobe_n_o, flash_dq_oe_o;
	int err_count = 0;
	int n_checks = 0;
	int took;
	localparam int GAP_CYC = 100;
	assign dq = flash_dq_oe_o ? flash_dq_o : dev_dq;
	always #50 clk_i = ~clk_i;
	always @(posedge write_strobe_n_o)
		wr_data = dq;
	flash_command_host #(.RESUME_GAP(GAP_CYC), .POLL_LIMIT(2000)) flash_command_host_inst (
		.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .op_i(op_i), .addr_i(addr_i),
		.data_i(data_i), .ready_o(ready_o), .done_o(done_o), .fail_o(fail_o),
		.suspended_o(suspended_o), .rdata_o(rdata_o), .flash_addr_o(flash_addr_o),
		.chip_select_n_o(chip_select_n_o), .write_strobe_n_o(write_strobe_n_o),
		.output_strobe_n_o(output_strobe_n_o), .flash_dq_o(flash_dq_o),
		.flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(dq));
	flash_model flash_model_inst (.addr_i(flash_addr_o), .chip_select_n_i(chip_select_n_o),
		.write_strobe_n_i(write_strobe_n_o), .output_strobe_n_i(output_strobe_n_o),
		.dq_i(dq), .dq_o(dev_dq));
	task automatic final_report;
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic op(input flash_host_pkg::op_type o, input logic [19:0] a, input logic [15:0] d);
		@(posedge clk_i);
		while (ready_o !== 1'b1)
			@(posedge clk_i);
		req_i <= 1'b1;
		op_i <= o;
		addr_i <= a;
		data_i <= d;
		@(posedge clk_i);
		req_i <= 1'b0;
		took = 0;
		while (done_o !== 1'b1 && took < 20000) begin
			@(posedge clk_i);
			took++;
		end
		chk("done", 16'h0001, {15'h0000, done_o});
	endtask
	task automatic wait_erased(input logic [19:0] a);
		int k;
		k = 0;
		do begin
			op(flash_host_pkg::OP_READ, a, 16'h0000);
			k++;
		end while (rdata_o !== 16'hFFFF && k < 2000);
	endtask
	task automatic t_power;
		op(flash_host_pkg::OP_READ, 20'h00010, 16'h0000);
		chk("array", 16'hFFFF, rdata_o);
		op(flash_host_pkg::OP_RESET, 20'hABCDE, 16'h0000);
		chk("reset code", 16'h00F0, wr_data);
	endtask
	task automatic t_prog;
		op(flash_host_pkg::OP_PROGRAM, 20'h00100, 16'h1234);
		chk("program", 16'h1234, rdata_o);
		chk("program word", 16'h1234, wr_data);
		op(flash_host_pkg::OP_PROGRAM, 20'h00100, 16'h1274);
		chk("no one", 16'h1234, rdata_o);
		chk("no fail", 16'h0000, {15'h0000, fail_o});
	endtask
	task automatic t_fail;
		op(flash_host_pkg::OP_SUSPEND, 20'h00100, 16'h0000);
		chk("time out", 16'h0001, {15'h0000, fail_o});
		chk("abort code", 16'h00F0, wr_data);
		chk("no erase", 16'h0000, {15'h0000, suspended_o});
		op(flash_host_pkg::OP_READ, 20'h00100, 16'h0000);
		chk("fail cleared", 16'h0000, {15'h0000, fail_o});
	endtask
	task automatic t_erase;
		op(flash_host_pkg::OP_PROGRAM, 20'h03005, 16'h00AA);
		op(flash_host_pkg::OP_PROGRAM, 20'h04002, 16'h0001);
		op(flash_host_pkg::OP_ERASE, 20'h03000, 16'h0000);
		chk("erase code", 16'h0030, wr_data);
		op(flash_host_pkg::OP_LOAD, 20'h04000, 16'h0000);
		op(flash_host_pkg::OP_READ, 20'h04002, 16'h0000);
		chk("erase poll", 16'h0000, rdata_o & 16'h0080);
		wait_erased(20'h03005);
		chk("erased", 16'hFFFF, rdata_o);
		op(flash_host_pkg::OP_READ, 20'h04002, 16'h0000);
		chk("loaded", 16'hFFFF, rdata_o);
		op(flash_host_pkg::OP_READ, 20'h00100, 16'h0000);
		chk("kept", 16'h1234, rdata_o);
	endtask
	task automatic t_abort;
		op(flash_host_pkg::OP_PROGRAM, 20'h06001, 16'h0033);
		op(flash_host_pkg::OP_ERASE, 20'h06000, 16'h0000);
		op(flash_host_pkg::OP_RESET, 20'h00000, 16'h0000);
		op(flash_host_pkg::OP_READ, 20'h06001, 16'h0033);
		chk("abort", 16'h0033, rdata_o);
	endtask
	task automatic t_susp;
		op(flash_host_pkg::OP_PROGRAM, 20'h05001, 16'h0011);
		op(flash_host_pkg::OP_ERASE, 20'h05000, 16'h0000);
		repeat (700) @(posedge clk_i);
		op(flash_host_pkg::OP_SUSPEND, 20'h05001, 16'h0000);
		chk("suspended", 16'h0001, {15'h0000, suspended_o});
		op(flash_host_pkg::OP_READ, 20'h05001, 16'h0000);
		chk("status", 16'h0080, rdata_o & 16'h0080);
		op(flash_host_pkg::OP_PROGRAM, 20'h00200, 16'h0077);
		chk("side program", 16'h0077, rdata_o);
		op(flash_host_pkg::OP_RESUME, 20'h05000, 16'h0000);
		chk("resumed", 16'h0000, {15'h0000, suspended_o});
		op(flash_host_pkg::OP_SUSPEND, 20'h05001, 16'h0000);
		chk("gap", 16'h0001, {15'h0000, took >= GAP_CYC - 8});
		op(flash_host_pkg::OP_RESUME, 20'h05000, 16'h0000);
		wait_erased(20'h05001);
		chk("erased after resume", 16'hFFFF, rdata_o);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_power();
		t_prog();
		t_fail();
		t_erase();
		t_abort();
		t_susp();
		final_report();
	end
	// whole run needs some 8000 cycles
	initial begin
		repeat (80000) @(posedge clk_i);
		err_count++;
		final_report();
	end
endmodule
`default_nettype wire
